/* File: rtl/smic_pkg.sv */
package smic_pkg;
  // register offsets inside the peripheral control block
  localparam logic [7:0] OFF_VECTOR = 8'h20;
  localparam logic [7:0] OFF_EOI = 8'h22;
  localparam logic [7:0] OFF_MASK = 8'h28;
  localparam logic [7:0] OFF_THRESH = 8'h2a;
  localparam logic [7:0] OFF_INSERV = 8'h2c;
  localparam logic [7:0] OFF_REQUEST = 8'h2e;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_CTL_T0 = 8'h32;
  localparam logic [7:0] OFF_CTL_D0 = 8'h34;
  localparam logic [7:0] OFF_CTL_D1 = 8'h36;
  localparam logic [7:0] OFF_CTL_T1 = 8'h38;
  localparam logic [7:0] OFF_CTL_T2 = 8'h3a;
  localparam logic [7:0] OFF_RELOC = 8'hfe;
  // source bit positions in in-service, request and mask words
  localparam int SRC_T0 = 0;
  localparam int SRC_D0 = 2;
  localparam int SRC_D1 = 3;
  localparam int SRC_T1 = 4;
  localparam int SRC_T2 = 5;
  localparam int NSRC = 6;
  localparam logic [5:0] SRC_USED = 6'h3d;
  // field positions
  localparam int CTL_MSK_BIT = 3;
  localparam int RELOC_SLAVE_BIT = 14;
  localparam int VEC_HI_LSB = 3;
  // reset values
  localparam logic [2:0] PR_LOWEST = 3'h7;
  localparam logic [2:0] THRESH_RST = 3'h7;
  localparam logic [4:0] VEC_RST = 5'h00;
endpackage

/* File: rtl/smic_top.sv */
`timescale 1ns/10ps
// Function
// [R1] forward master interrupt to cpu, raise request to master when pending
// [R2] external decoder asserts slave select when our cascade address appears
// [R3] vector transferred internally, external ready ends the acknowledge
// [R4] acknowledge output suited to drive the master's acknowledge input
// [R5] on acknowledge, only equal or higher priority levels remain enabled
// [R6] vector is five programmed upper bits plus three priority level bits
// [R7] upper vector bits live in the vector register at offset 20h
// [R8] writing a level to offset 22h clears in-service bit of that level
// [R9] end-of-interrupt register is write-only, each write is a command
// [R10] in-service register read/write, dma bits 2,3, timer bits 0,4,5
// [R11] in-service bit set when the processor acknowledges that source
// [R12] request bit set by source event, cleared by acknowledge
// [R13] only the two dma request bits are software writable
// [R14] set mask bit blocks source; one flop shared by mask and control
// [R15] each timer and dma channel has control word: priority and mask
// [R16] threshold register masks all priorities lower than its value
// [R17] status register as in master operation, dma halt not present
// [R18] reset: priorities 111, in-service and requests cleared
// [R19] reset: masks set, threshold 111, master operation
// [R20] relocation bit 14 selects slave operation
// [R21] priority code 000 is highest, 111 lowest
// [R22] timer request bits in status register, setting one raises request
// [R23] software gives unique priorities and sets up before enabling
module smic_top
  import smic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // peripheral control block access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // internal sources, one-cycle pulses
  input wire logic [2:0] timer_evt,
  input wire logic [1:0] dma_evt,
  // cascade interface to the external master
  input wire logic cpu_irq_input,
  input wire logic slave_select,
  input wire logic cpu_ack,
  input wire logic ack_ready,
  output logic cpu_int,
  output logic slave_irq,
  output logic slave_ack_out_n,
  // vector handed to the cpu
  output logic [7:0] vector,
  output logic vector_valid
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [2:0] pr_ff [NSRC];
  logic [5:0] msk_ff;
  logic [5:0] isr_ff;
  logic [1:0] dreq_ff;
  logic [2:0] treq_ff;
  logic [2:0] thresh_ff;
  logic [4:0] vec_hi_ff;
  logic slave_mode_ff;
  logic ack_d_ff;
  logic busy_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;
  logic int_ff;
  logic ack_n_ff;
  logic [7:0] vector_ff;
  logic vvalid_ff;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire wr_vec = reg_wr && reg_addr == OFF_VECTOR;
  wire wr_eoi = reg_wr && reg_addr == OFF_EOI;
  wire wr_mask = reg_wr && reg_addr == OFF_MASK;
  wire wr_thr = reg_wr && reg_addr == OFF_THRESH;
  wire wr_isr = reg_wr && reg_addr == OFF_INSERV;
  wire wr_req = reg_wr && reg_addr == OFF_REQUEST;
  wire wr_stat = reg_wr && reg_addr == OFF_STATUS;
  wire wr_rel = reg_wr && reg_addr == OFF_RELOC;
  logic [7:0] ctl_off [NSRC];
  assign ctl_off[0] = OFF_CTL_T0;
  assign ctl_off[1] = 8'h00;
  assign ctl_off[2] = OFF_CTL_D0;
  assign ctl_off[3] = OFF_CTL_D1;
  assign ctl_off[4] = OFF_CTL_T1;
  assign ctl_off[5] = OFF_CTL_T2;

  // request word in in-service layout; each timer has its own bit here
  wire [5:0] req_vec = {treq_ff[2], treq_ff[1], dreq_ff[1], dreq_ff[0],
                        1'b0, treq_ff[0]};
  // acknowledge is taken on the rising edge of cpu_ack with select set
  wire ack_edge = cpu_ack && !ack_d_ff;
  wire take_ack = ack_edge && slave_select && slave_mode_ff && !busy_ff;

  // -------------------------------------------------------------------
  // priority resolution
  // -------------------------------------------------------------------
  logic [2:0] ceil_pr;
  logic [5:0] elig;
  logic any_pend;
  logic [2:0] win_idx;
  logic [2:0] win_pr;
  // [R5] nesting ceiling from in-service levels
  always_comb
  begin
    ceil_pr = PR_LOWEST;
    for (int i = 0; i < NSRC; i++)
      if (SRC_USED[i] && isr_ff[i] && pr_ff[i] < ceil_pr)
        ceil_pr = pr_ff[i];
  end
  // [R14] [R16] mask and threshold gating; equal level may nest
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
      elig[i] = SRC_USED[i] && req_vec[i] && !msk_ff[i] &&
                pr_ff[i] <= thresh_ff && pr_ff[i] <= ceil_pr;
  end
  // [R21] lowest code wins; ties go to the lower bit, software avoids them
  always_comb
  begin
    any_pend = 1'b0;
    win_idx = 3'h0;
    win_pr = PR_LOWEST;
    for (int i = 0; i < NSRC; i++)
      if (elig[i] && (!any_pend || pr_ff[i] < win_pr))
      begin
        any_pend = 1'b1;
        win_idx = 3'(i);
        win_pr = pr_ff[i];
      end
  end
  wire [5:0] ack_hit = take_ack && any_pend ? 6'(6'h01 << win_idx) : 6'h00;

  // -------------------------------------------------------------------
  // in-service bits
  // -------------------------------------------------------------------
  logic [5:0] eoi_hit;
  // [R8] end of interrupt matches level against each source priority
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
      eoi_hit[i] = wr_eoi && pr_ff[i] == reg_wdata[2:0];
  end
  // [R10] [R11] write, eoi clear, acknowledge set; set wins
  wire [5:0] nxt_isr = ((wr_isr ? reg_wdata[5:0] : isr_ff) & ~eoi_hit
                        | ack_hit) & SRC_USED;
  always_ff @(posedge mclk)
  begin
    if (rst)
      isr_ff <= 6'h00;
    else
      isr_ff <= nxt_isr;
  end

  // -------------------------------------------------------------------
  // requests
  // -------------------------------------------------------------------
  // [R12] [R13] dma bits writable; event beats write and acknowledge
  wire [1:0] nxt_dreq = ((wr_req ? {reg_wdata[SRC_D1], reg_wdata[SRC_D0]}
                          : dreq_ff) & ~{ack_hit[SRC_D1], ack_hit[SRC_D0]})
                        | dma_evt;
  // [R22] timer bits written through status, cleared on acknowledge
  wire [2:0] nxt_treq = ((wr_stat ? reg_wdata[2:0] : treq_ff) &
                         ~{ack_hit[SRC_T2], ack_hit[SRC_T1], ack_hit[SRC_T0]})
                        | timer_evt;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dreq_ff <= 2'h0;
      treq_ff <= 3'h0;
    end
    else
    begin
      dreq_ff <= nxt_dreq;
      treq_ff <= nxt_treq;
    end
  end

  // -------------------------------------------------------------------
  // control words and masks
  // -------------------------------------------------------------------
  // [R14] [R15] one mask flop written by mask word or control word
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      wire wr_ctl = reg_wr && reg_addr == ctl_off[g] && SRC_USED[g];
      always_ff @(posedge mclk)
      begin
        // [R18] [R19] lowest priority and masked after reset
        if (rst)
        begin
          pr_ff[g] <= PR_LOWEST;
          msk_ff[g] <= 1'b1;
        end
        else if (wr_ctl)
        begin
          pr_ff[g] <= reg_wdata[2:0];
          msk_ff[g] <= reg_wdata[CTL_MSK_BIT];
        end
        else if (wr_mask)
          msk_ff[g] <= reg_wdata[g] || !SRC_USED[g];
      end
    end
  endgenerate

  // [R7] [R16] [R20] vector base, threshold and mode select
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      vec_hi_ff <= VEC_RST;
      thresh_ff <= THRESH_RST;
      slave_mode_ff <= 1'b0;
    end
    else
    begin
      if (wr_vec)
        vec_hi_ff <= reg_wdata[7:VEC_HI_LSB];
      if (wr_thr)
        thresh_ff <= reg_wdata[2:0];
      if (wr_rel)
        slave_mode_ff <= reg_wdata[RELOC_SLAVE_BIT];
    end
  end

  // -------------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------------
  logic [15:0] rd_mux;
  // [R9] end of interrupt reads back as zero, like unmapped offsets
  always_comb
  begin
    rd_mux = 16'h0000;
    for (int i = 0; i < NSRC; i++)
      if (SRC_USED[i] && reg_addr == ctl_off[i])
        rd_mux = {12'h000, msk_ff[i], pr_ff[i]};
    unique case (reg_addr)
      OFF_VECTOR: rd_mux = {8'h00, vec_hi_ff, 3'h0};
      OFF_MASK: rd_mux = {10'h000, msk_ff & SRC_USED};
      OFF_THRESH: rd_mux = {13'h0000, thresh_ff};
      OFF_INSERV: rd_mux = {10'h000, isr_ff};
      OFF_REQUEST: rd_mux = {10'h000, req_vec};
      // [R17] status holds only timer bits, halt bit reads zero
      OFF_STATUS: rd_mux = {13'h0000, treq_ff};
      OFF_RELOC: rd_mux = 16'(slave_mode_ff) << RELOC_SLAVE_BIT;
      default: ;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
      rdata_ff <= rd_mux;
  end

  // -------------------------------------------------------------------
  // cascade handshake
  // -------------------------------------------------------------------
  // [R1] [R4] [R6] request, acknowledge and vector toward master and cpu
  // [R2] select is decoded outside, taken as given here
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_d_ff <= 1'b0;
      busy_ff <= 1'b0;
      irq_ff <= 1'b0;
      int_ff <= 1'b0;
      ack_n_ff <= 1'b1;
      vector_ff <= 8'h00;
      vvalid_ff <= 1'b0;
    end
    else
    begin
      ack_d_ff <= cpu_ack;
      int_ff <= cpu_irq_input;
      // drop the request on the acknowledge edge so it never overlaps busy
      irq_ff <= slave_mode_ff && any_pend && !busy_ff && !take_ack;
      ack_n_ff <= !(cpu_ack && slave_mode_ff);
      // [R3] vector held until external ready closes the cycle
      if (take_ack)
      begin
        busy_ff <= 1'b1;
        vvalid_ff <= 1'b1;
        vector_ff <= {vec_hi_ff, win_pr};
      end
      else if (busy_ff && ack_ready)
      begin
        busy_ff <= 1'b0;
        vvalid_ff <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign cpu_int = int_ff;
  assign slave_irq = irq_ff;
  assign slave_ack_out_n = ack_n_ff;
  assign vector = vector_ff;
  assign vector_valid = vvalid_ff;

endmodule

/* File: testbench/smic_props.sv */
`timescale 1ns/10ps
module smic_props
  import smic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic cpu_irq_input,
  input wire logic slave_select,
  input wire logic cpu_ack,
  input wire logic ack_ready,
  input wire logic cpu_int,
  input wire logic slave_irq,
  input wire logic slave_ack_out_n,
  input wire logic [7:0] vector,
  input wire logic vector_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // one-cycle lag is the designer's choice
  property p_fwd; 1 |=> cpu_int == $past(cpu_irq_input); endproperty
  a_fwd: assert property (p_fwd) else $error("irq not forwarded");
  property p_ackn; !slave_ack_out_n |-> $past(cpu_ack); endproperty
  a_ackn: assert property (p_ackn) else $error("ack out early");
  property p_ackh; !cpu_ack |=> slave_ack_out_n; endproperty
  a_ackh: assert property (p_ackh) else $error("ack out stuck");
  property p_vrise;
    $rose(vector_valid) |-> $past(cpu_ack && slave_select) && !$past(cpu_ack, 2);
  endproperty
  a_vrise: assert property (p_vrise) else $error("bad vector start");
  property p_vhold;
    vector_valid && !ack_ready |=> vector_valid && $stable(vector);
  endproperty
  a_vhold: assert property (p_vhold) else $error("vector dropped");
  property p_vdrop; vector_valid && ack_ready |=> !vector_valid; endproperty
  a_vdrop: assert property (p_vdrop) else $error("vector stuck");
  property p_busy; vector_valid |-> !slave_irq; endproperty
  a_busy: assert property (p_busy) else $error("irq while busy");
  property p_rdata; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  c_vec: cover property ($rose(vector_valid));
  c_end: cover property (vector_valid && ack_ready);
  c_irq: cover property ($rose(slave_irq));
endmodule
bind smic_top smic_props i_props (.*);

/* File: testbench/smic_master_model.sv */
`timescale 1ns/10ps
module smic_master_model
  import smic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench commands
  input wire logic sel_en,
  input wire logic [3:0] delay,
  // cascade side
  input wire logic slave_irq,
  output logic cpu_irq_input,
  output logic cpu_ack,
  output logic slave_select,
  output logic ack_ready
);
  logic [1:0] ph_ff = 2'h0;
  logic [3:0] cnt_ff = 4'h0;
  logic tog_ff = 1'h0;
  // idle, wait, acknowledge, ready; delay sets fast or slow answers
  always_ff @(posedge mclk)
  begin
    tog_ff <= ~tog_ff;
    cnt_ff <= cnt_ff + 4'h1;
    if (rst)
      ph_ff <= 2'h0;
    else if (ph_ff == 2'h0 ? slave_irq : ph_ff == 2'h3 || cnt_ff >= delay)
    begin
      ph_ff <= ph_ff + 2'h1;
      cnt_ff <= 4'h0;
    end
  end
  assign cpu_irq_input = ph_ff != 2'h0;
  assign cpu_ack = ph_ff[1];
  assign ack_ready = ph_ff == 2'h3;
  // external decode; other slaves' codes make it toggle outside
  assign slave_select = ph_ff[1] ? sel_en : tog_ff;
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import smic_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [15:0] d, e;} smic_row_t;
  logic mclk, rst, reg_wr, reg_rd, sel_en, cpu_irq_input, slave_select;
  logic cpu_ack, ack_ready, cpu_int, slave_irq, slave_ack_out_n;
  logic vector_valid;
  logic [7:0] reg_addr, vector;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] timer_evt;
  logic [1:0] dma_evt;
  logic [3:0] delay;
  int err_total, cmp_count, cyc;
  // unique priorities: dma0 at 2, timer0 at 3
  smic_row_t rows [19] = '{
    '{1'h0, 8'h28, 16'h0, 16'h003d}, '{1'h0, 8'h2a, 16'h0, 16'h0007},
    '{1'h0, 8'h32, 16'h0, 16'h000f}, '{1'h1, 8'h20, 16'hffff, 16'h00f8},
    '{1'h1, 8'h2c, 16'hffff, 16'h003d}, '{1'h1, 8'h22, 16'h7, 16'h0000},
    '{1'h0, 8'h2c, 16'h0, 16'h0000}, '{1'h1, 8'h2e, 16'hffff, 16'h000c},
    '{1'h1, 8'h2e, 16'h0, 16'h0000}, '{1'h1, 8'h2a, 16'hfffc, 16'h0004},
    '{1'h1, 8'h40, 16'hffff, 16'h0}, '{1'h1, 8'hfe, 16'h4000, 16'h4000},
    '{1'h1, 8'h36, 16'hfffd, 16'h000d}, '{1'h1, 8'h3a, 16'h000e, 16'h000e},
    '{1'h1, 8'h34, 16'h2, 16'h0002}, '{1'h0, 8'h28, 16'h0, 16'h0039},
    '{1'h1, 8'h32, 16'h3, 16'h0003}, '{1'h1, 8'h2a, 16'h7, 16'h0007},
    '{1'h1, 8'h20, 16'ha8, 16'h00a8}};
  smic_top i_dut (.*);
  smic_master_model i_master (.*);
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic fire(input logic [2:0] t, input logic [1:0] d);
    @(posedge mclk);
    timer_evt <= t;
    dma_evt <= d;
    @(posedge mclk);
    timer_evt <= 3'h0;
    dma_evt <= 2'h0;
  endtask
  // wait for the slave vector, then for the cycle to close
  task automatic vec(input logic [7:0] e);
    int n;
    for (n = 0; n < 200 && vector_valid !== 1'b1; n++)
      @(posedge mclk) #1;
    // acknowledge out must be low as the vector appears
    chk({6'h0, slave_ack_out_n, vector_valid, vector}, {8'h01, e});
    while (vector_valid === 1'b1)
      @(posedge mclk) #1;
  endtask
  // any request or vector during the window counts, not only the last cycle
  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge mclk) #1;
      seen = seen | slave_irq | vector_valid;
    end
    chk({15'h0, seen}, 16'h0);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the run's length
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    {rst, sel_en} = 2'h3;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {timer_evt, dma_evt, delay} = 9'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("register table done");
    fire(3'h1, 2'h0);
    vec(8'hab);
    rd(8'h2c, 16'h0001);
    rd(8'h2e, 16'h0000);
    delay <= 4'h6;
    fire(3'h0, 2'h1);
    vec(8'haa);
    fire(3'h1, 2'h0);
    quiet();
    wr(8'h22, 16'h0002);
    vec(8'hab);
    wr(8'h22, 16'h0003);
    rd(8'h2c, 16'h0000);
    $display("nesting done");
    sel_en <= 1'b0;
    fire(3'h1, 2'h0);
    repeat (30) @(posedge mclk);
    sel_en <= 1'b1;
    vec(8'hab);
    wr(8'h22, 16'h0003);
    wr(8'h2a, 16'h0002);
    fire(3'h1, 2'h0);
    quiet();
    wr(8'h2a, 16'h0003);
    vec(8'hab);
    wr(8'h30, 16'h0002);
    rd(8'h2e, 16'h0010);
    wr(8'h38, 16'h0001);
    vec(8'ha9);
    $display("cascade done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h28, 16'h003d);
    rd(8'hfe, 16'h0000);
    chk({4'h0, slave_ack_out_n, vector_valid, slave_irq, cpu_int, vector},
        16'h0800);
    $display("reset done");
    test_done();
  end
endmodule
